// [dv/ltbo_binner.sv]
// External binning circuit watching the four output lines
`timescale 1ns/1ps
`default_nettype none
module ltbo_binner (
  input  wire logic       ref_clk,
  input  wire logic [3:0] pol,
  input  wire logic [3:0] lines,
  output logic      [2:0] bin_code,
  output int              width
);
  logic on;
  logic on_q;
  int   run;
  // Strobe level follows line four's polarity
  assign on = lines[3] == pol[3];
  // Bin lines trusted only at the strobe's leading edge
  always_ff @(posedge ref_clk) begin
    on_q <= on;
    if (on && !on_q) begin
      bin_code <= lines[2:0] ~^ pol[2:0]; // Levels back to pattern bits
    end
    run <= on ? run + 1 : 0;
    if (!on && on_q) begin
      width <= run; // Strobe length in cycles
    end
  end
endmodule
`default_nettype wire

// [dv/ltbo_checker.sv]
// Port checker for the limit-test evaluator
`timescale 1ns/1ps
`default_nettype none
`include "ltbo_regs.svh"
module ltbo_checker (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                clk_en,
  input wire ltbo_pkg::ltbo_bus_t bus,
  input wire logic         [31:0] rdata,
  input wire logic                meas_valid,
  input wire logic         [31:0] meas_value,
  input wire logic                trig_idle,
  input wire logic          [3:0] port_lines,
  input wire logic          [1:0] fail_flags
);
  logic [4:0] ctrl_q;
  // Shadow of the control word; no output port shows which windows are on
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `LTBO_CTRL_RST;
    end else if (clk_en && bus.wr && bus.addr == `LTBO_OFF_CTRL) begin
      ctrl_q <= bus.wdata[4:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !clk_en);
  // Line four left out: the strobe moves it on its own schedule
  a_port_once: assert property (
    $changed(port_lines[2:0]) |-> $past(meas_valid) || $past(bus.wr))
    else $error("Port lines moved without a cause");
  a_flags_hold: assert property (
    $changed(fail_flags) |-> $past(meas_valid) || $past(bus.wr) || $past(trig_idle))
    else $error("Fail flags moved without a cause");
  a_flag_rise: assert property (
    $rose(fail_flags[0]) || $rose(fail_flags[1]) |-> $past(meas_valid))
    else $error("Fail flag set without a measurement");
  a_status_read: assert property (
    bus.rd && bus.addr == `LTBO_OFF_STATUS |=> rdata == {30'h0, $past(fail_flags)})
    else $error("Status read does not show the flags");
  a_clear_flag: assert property (
    bus.wr && bus.addr == `LTBO_OFF_CLEAR && bus.wdata[0] && !meas_valid |=> !fail_flags[0])
    else $error("Clear left window one flag set");
  a_self_clr: assert property (
    trig_idle && ctrl_q[`LTBO_CTRL_W2_AUTO] && !meas_valid |=> !fail_flags[1])
    else $error("Idle did not clear window two flag");
  a_off_quiet: assert property (
    (fail_flags & ~ctrl_q[1:0]) == 2'h0)
    else $error("Flag set on a disabled window");
  a_direct_block: assert property (
    bus.wr && bus.addr == `LTBO_OFF_DIRECT && ctrl_q[1:0] != 2'h0 && !meas_valid
    |=> $stable(port_lines[2:0]))
    else $error("Direct write reached an enabled port");
  a_meas_refused: assert property (
    meas_valid && ctrl_q[1:0] == 2'h0 && !bus.wr |=> $stable(port_lines[2:0]))
    else $error("Measurement acted with windows off");
  c_fail: cover property (meas_valid ##1 fail_flags != 2'h0);
  c_strobe: cover property ($fell(port_lines[3]) && ctrl_q[`LTBO_CTRL_STROBE]);
  c_idle: cover property (trig_idle ##1 fail_flags == 2'h0);
endmodule
bind ltbo_top ltbo_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
  .meas_valid(meas_valid), .meas_value(meas_value), .trig_idle(trig_idle),
  .port_lines(port_lines), .fail_flags(fail_flags)
);
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the limit-test evaluator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  ltbo_pkg::ltbo_bus_t bus = '0;
  logic                meas_valid = 1'b0;
  logic         [31:0] meas_value = 32'h0;
  logic                trig_idle = 1'b0;
  logic          [3:0] pol = 4'hf;
  logic                clk_en = 1'b1;
  logic         [31:0] rdata;
  logic          [3:0] port_lines;
  logic          [1:0] fail_flags;
  logic          [2:0] bin_code;
  int                  width;
  int                  err_count = 0;
  int                  n_compared = 0;
  // Readings around both windows: -10..10 and -5..5, boundaries -10, 10 and 5 included
  logic [31:0] mv [8] = '{32'h0, 32'h7, 32'hfffffff9, 32'h14, 32'hffffffec, 32'ha,
                          32'hfffffff6, 32'h5};
  logic  [3:0] mp [8] = '{4'ha, 4'h8, 4'hc, 4'h6, 4'h1, 4'h8, 4'hc, 4'ha};
  logic  [1:0] mf [8] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0};
  ltbo_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .meas_valid(meas_valid), .meas_value(meas_value), .trig_idle(trig_idle),
    .port_lines(port_lines), .fail_flags(fail_flags)
  );
  ltbo_binner u_bin (
    .ref_clk(ref_clk), .pol(pol), .lines(port_lines), .bin_code(bin_code), .width(width)
  );
  always #20 ref_clk = ~ref_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Bus cycles: strobe for one edge, then settle before any look
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
    #1;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task meas(input logic [31:0] v, input logic [3:0] ep, input logic [1:0] ef);
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas_value <= v;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    #1;
    chk(port_lines, ep);
    chk(fail_flags, ef);
  endtask
  task idle(input logic [1:0] ef);
    @(posedge ref_clk);
    trig_idle <= 1'b1;
    @(posedge ref_clk);
    trig_idle <= 1'b0;
    #1;
    chk(fail_flags, ef);
  endtask
  task final_report;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(8'h00, 32'hc);
    rdc(8'h1c, 32'h1);
    rdc(8'h20, 32'hffffffff);
    rdc(8'h0c, 32'h0);
    rdc(8'h3c, 32'h0);
    wr(8'h0c, 32'ha8c61);
    rdc(8'h0c, 32'ha8c61);
    wr(8'h18, 32'hfffffff6);
    wr(8'h1c, 32'ha);
    wr(8'h20, 32'hfffffffb);
    wr(8'h24, 32'h5);
    wr(8'h00, 32'h3);
    rdc(8'h00, 32'h3);
    for (int i = 0; i < 8; i++) begin
      meas(mv[i], mp[i], mf[i]);
    end
    meas(32'h14, 4'h6, 2'h3);
    // Clock enable low: a measurement must leave port and flags frozen
    @(posedge ref_clk);
    clk_en <= 1'b0;
    meas(32'h0, 4'h6, 2'h3);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rdc(8'h04, 32'h3);
    rdc(8'h04, 32'h3);
    wr(8'h14, 32'h5);
    chk(port_lines, 4'h6);
    wr(8'h08, 32'h1);
    chk(fail_flags, 2'h2);
    idle(2'h2);
    wr(8'h00, 32'hf);
    idle(2'h0);
    meas(32'h14, 4'h6, 2'h3);
    wr(8'h00, 32'h1);
    chk(fail_flags, 2'h1);
    meas(32'h7, 4'ha, 2'h0);
    wr(8'h00, 32'h0);
    meas(32'h14, 4'ha, 2'h0);
    wr(8'h14, 32'h5);
    chk(port_lines, 4'h5);
    // Line four active low, strobe on: settle, then a long pulse
    wr(8'h10, 32'h6);
    pol <= 4'h6;
    wr(8'h00, 32'h13);
    meas(32'hffffffec, 4'h8, 2'h3);
    repeat (260) @(posedge ref_clk);
    chk(bin_code, 3'h1);
    chk(width > 250, 1'b1);
    meas(32'hfffffff9, 4'hd, 2'h2);
    repeat (260) @(posedge ref_clk);
    chk(bin_code, 3'h4);
    final_report;
  end
  // Watchdog at 2500 cycles, well past the few hundred cycles the tests need
  initial begin
    #100000;
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire

// [hw/ltbo_pkg.sv]
// Types shared by the limit-test evaluator
package ltbo_pkg;

  typedef enum logic [1:0] {
    LTBO_IDLE,
    LTBO_SETTLE,
    LTBO_PULSE
  } ltbo_phase_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ltbo_bus_t;

  typedef struct packed {
    logic [31:0] w1_lower;
    logic [31:0] w1_upper;
    logic [31:0] w2_lower;
    logic [31:0] w2_upper;
    logic [19:0] pattern;
    logic [3:0]  polarity;
    logic [3:0]  direct;
    logic [4:0]  ctrl;
    logic [1:0]  fail;
    logic [3:0]  port_true;
    logic        strobe_true;
    logic [3:0]  port_lines;
    logic [31:0] rdata;
    ltbo_phase_t phase;
    logic [8:0]  count;
  } ltbo_state_t;

endpackage

// [hw/ltbo_regs.svh]
// Register offsets, fields, reset values and timing counts of the limit-test evaluator
// Overview of operation
// - Four failure patterns, 0 to 15, reset 0
// - Earliest failing check selects the port pattern
// - Pattern bits weight lines 1,2,4,8
// - Asserted line level follows its polarity
// - Strobe enabled ignores bit 3, line four
// - Per-window enable bit, both off at reset
// - Check order lower1, upper1, lower2, upper2
// - Disabled window skipped, cannot fail
// - All enabled pass gives pass pattern
// - Later checks still update fail flags
// - Enabled window blocks direct port writes
// - Disabling a window clears its flag
// - Fail flag 1 on fail, 0 on pass
// - Reading fail flag has no side effect
// - Host clear action resets a window flag
// - Self-clear bit clears flag on idle
// - Signed bounds, upper 1 lower -1 reset
// - Pass pattern 0 to 15, reset 0
// - Settle lines, then strobe over 10 us
`ifndef LTBO_REGS_SVH
`define LTBO_REGS_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define LTBO_OFF_CTRL      8'h00
`define LTBO_OFF_STATUS    8'h04
`define LTBO_OFF_CLEAR     8'h08
`define LTBO_OFF_PATTERN   8'h0c
`define LTBO_OFF_POLARITY  8'h10
`define LTBO_OFF_DIRECT    8'h14
`define LTBO_OFF_W1_LOWER  8'h18
`define LTBO_OFF_W1_UPPER  8'h1c
`define LTBO_OFF_W2_LOWER  8'h20
`define LTBO_OFF_W2_UPPER  8'h24

// Control register fields
`define LTBO_CTRL_W1_EN    0
`define LTBO_CTRL_W2_EN    1
`define LTBO_CTRL_W1_AUTO  2
`define LTBO_CTRL_W2_AUTO  3
`define LTBO_CTRL_STROBE   4
`define LTBO_CTRL_RST      5'h0c

// Pattern register nibbles
`define LTBO_PAT_W1_LOW    0
`define LTBO_PAT_W1_UPP    4
`define LTBO_PAT_W2_LOW    8
`define LTBO_PAT_W2_UPP    12
`define LTBO_PAT_PASS      16

// Bound reset values
`define LTBO_UPPER_RST     32'h0000_0001
`define LTBO_LOWER_RST     32'hffff_ffff

// Strobe timing
`define LTBO_CLK_MHZ       25
`define LTBO_STROBE_NS     10000
`define LTBO_SETTLE_CYC    2
`define LTBO_STROBE_CYC    ((`LTBO_STROBE_NS * `LTBO_CLK_MHZ) / 1000 + 1)

`endif

// [hw/ltbo_top.sv]
// Limit-test evaluator driving the four-line binning output port
`timescale 1ns/1ps
`default_nettype none
`include "ltbo_regs.svh"

module ltbo_top (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire ltbo_pkg::ltbo_bus_t bus,
  output logic        [31:0] rdata,
  input  wire logic          meas_valid,
  input  wire logic   [31:0] meas_value,
  input  wire logic          trig_idle,
  output logic        [3:0]  port_lines,
  output logic        [1:0]  fail_flags
);

  localparam logic [8:0] STROBE_CYC = 9'(`LTBO_STROBE_CYC);
  localparam logic [8:0] SETTLE_CYC = 9'(`LTBO_SETTLE_CYC);

  ltbo_pkg::ltbo_state_t st_reg;
  ltbo_pkg::ltbo_state_t st_next;

  // Signed compare, used for all four checks
  function automatic logic below(input logic [31:0] a, input logic [31:0] b);
    below = $signed(a) < $signed(b);
  endfunction

  // Mask pattern bit 3 when line four carries the strobe
  function automatic logic [3:0] eff_pat(input logic [3:0] p, input logic strobe_on);
    eff_pat = strobe_on ? {1'b0, p[2:0]} : p;
  endfunction

  logic       chk_fail [4];
  logic [3:0] chk_pat  [4];
  logic       win_on   [4];
  logic [3:0] sel_pat;
  logic       any_fail;
  logic [1:0] fail_hit;
  logic [1:0] clr_hit;
  logic [4:0] ctrl_new;

  // Per-check outcome in sequence order
  always_comb begin
    chk_fail[0] = below(meas_value, st_reg.w1_lower);
    chk_fail[1] = below(st_reg.w1_upper, meas_value);
    chk_fail[2] = below(meas_value, st_reg.w2_lower);
    chk_fail[3] = below(st_reg.w2_upper, meas_value);
    chk_pat[0]  = st_reg.pattern[`LTBO_PAT_W1_LOW +: 4];
    chk_pat[1]  = st_reg.pattern[`LTBO_PAT_W1_UPP +: 4];
    chk_pat[2]  = st_reg.pattern[`LTBO_PAT_W2_LOW +: 4];
    chk_pat[3]  = st_reg.pattern[`LTBO_PAT_W2_UPP +: 4];
    win_on[0]   = st_reg.ctrl[`LTBO_CTRL_W1_EN];
    win_on[1]   = st_reg.ctrl[`LTBO_CTRL_W1_EN];
    win_on[2]   = st_reg.ctrl[`LTBO_CTRL_W2_EN];
    win_on[3]   = st_reg.ctrl[`LTBO_CTRL_W2_EN];
  end

  // Walk checks in order; first enabled failure wins
  always_comb begin
    sel_pat  = st_reg.pattern[`LTBO_PAT_PASS +: 4];
    any_fail = 1'b0;
    fail_hit = 2'b00;
    for (int i = 0; i < 4; i++) begin
      if (win_on[i] && chk_fail[i]) begin
        if (!any_fail) begin
          sel_pat = chk_pat[i];
        end
        any_fail = 1'b1;
        fail_hit[i / 2] = 1'b1;
      end
    end
  end

  // Next state: registers, flags, port and strobe sequencer
  always_comb begin
    st_next  = st_reg;
    clr_hit  = 2'b00;
    ctrl_new = st_reg.ctrl;
    if (bus.wr) begin
      unique case (bus.addr)
        `LTBO_OFF_CTRL:     ctrl_new = bus.wdata[4:0];
        `LTBO_OFF_CLEAR:    clr_hit = bus.wdata[1:0];
        `LTBO_OFF_PATTERN:  st_next.pattern = bus.wdata[19:0];
        `LTBO_OFF_POLARITY: st_next.polarity = bus.wdata[3:0];
        `LTBO_OFF_DIRECT:   st_next.direct = bus.wdata[3:0];
        `LTBO_OFF_W1_LOWER: st_next.w1_lower = bus.wdata;
        `LTBO_OFF_W1_UPPER: st_next.w1_upper = bus.wdata;
        `LTBO_OFF_W2_LOWER: st_next.w2_lower = bus.wdata;
        `LTBO_OFF_W2_UPPER: st_next.w2_upper = bus.wdata;
        default: ;
      endcase
    end
    st_next.ctrl = ctrl_new;
    // Host clear, idle self-clear and disable all drop the flag
    for (int w = 0; w < 2; w++) begin
      if (clr_hit[w] || !ctrl_new[w]) begin
        st_next.fail[w] = 1'b0;
      end
      if (trig_idle && st_reg.ctrl[`LTBO_CTRL_W1_AUTO + w]) begin
        st_next.fail[w] = 1'b0;
      end
    end
    // Measurement result; a new failure beats a same-cycle clear
    if (meas_valid) begin
      for (int w = 0; w < 2; w++) begin
        if (st_reg.ctrl[w]) begin
          st_next.fail[w] = fail_hit[w] && ctrl_new[w];
        end
      end
    end
    // Port update: once per sequence, direct writes only with both windows off
    if (meas_valid && (st_reg.ctrl[1:0] != 2'b00)) begin
      st_next.port_true = eff_pat(sel_pat, st_reg.ctrl[`LTBO_CTRL_STROBE]);
      if (st_reg.ctrl[`LTBO_CTRL_STROBE]) begin
        st_next.strobe_true = 1'b0;
        st_next.phase = ltbo_pkg::LTBO_SETTLE;
        st_next.count = SETTLE_CYC;
      end
    end else if (bus.wr && bus.addr == `LTBO_OFF_DIRECT && st_reg.ctrl[1:0] == 2'b00) begin
      st_next.port_true = bus.wdata[3:0];
    end
    // Strobe sequencer: settle lines first, then pulse line four
    unique case (st_reg.phase)
      ltbo_pkg::LTBO_IDLE: ;
      ltbo_pkg::LTBO_SETTLE: begin
        if (!(meas_valid && st_reg.ctrl[`LTBO_CTRL_STROBE])) begin
          if (st_reg.count == 9'h001) begin
            st_next.phase = ltbo_pkg::LTBO_PULSE;
            st_next.strobe_true = 1'b1;
            st_next.count = STROBE_CYC;
          end else begin
            st_next.count = st_reg.count - 9'h001;
          end
        end
      end
      ltbo_pkg::LTBO_PULSE: begin
        if (!(meas_valid && st_reg.ctrl[`LTBO_CTRL_STROBE])) begin
          if (st_reg.count == 9'h001) begin
            st_next.phase = ltbo_pkg::LTBO_IDLE;
            st_next.strobe_true = 1'b0;
          end else begin
            st_next.count = st_reg.count - 9'h001;
          end
        end
      end
    endcase
    if (!ctrl_new[`LTBO_CTRL_STROBE]) begin
      st_next.strobe_true = 1'b0;
      st_next.phase = ltbo_pkg::LTBO_IDLE;
    end
    // Line levels: strobe on line four when enabled, then polarity
    st_next.port_lines[2:0] = st_next.port_true[2:0] ~^ st_next.polarity[2:0];
    st_next.port_lines[3] = (ctrl_new[`LTBO_CTRL_STROBE] ? st_next.strobe_true
                             : st_next.port_true[3]) ~^ st_next.polarity[3];
    // Read data one cycle later; reads have no side effect
    st_next.rdata = 32'h0000_0000;
    if (bus.rd) begin
      unique case (bus.addr)
        `LTBO_OFF_CTRL:     st_next.rdata = {27'h0, st_reg.ctrl};
        `LTBO_OFF_STATUS:   st_next.rdata = {30'h0, st_reg.fail};
        `LTBO_OFF_PATTERN:  st_next.rdata = {12'h0, st_reg.pattern};
        `LTBO_OFF_POLARITY: st_next.rdata = {28'h0, st_reg.polarity};
        `LTBO_OFF_DIRECT:   st_next.rdata = {28'h0, st_reg.direct};
        `LTBO_OFF_W1_LOWER: st_next.rdata = st_reg.w1_lower;
        `LTBO_OFF_W1_UPPER: st_next.rdata = st_reg.w1_upper;
        `LTBO_OFF_W2_LOWER: st_next.rdata = st_reg.w2_lower;
        `LTBO_OFF_W2_UPPER: st_next.rdata = st_reg.w2_upper;
        default:            st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.w1_lower <= `LTBO_LOWER_RST;
      st_reg.w2_lower <= `LTBO_LOWER_RST;
      st_reg.w1_upper <= `LTBO_UPPER_RST;
      st_reg.w2_upper <= `LTBO_UPPER_RST;
      st_reg.ctrl     <= `LTBO_CTRL_RST;
      st_reg.polarity <= 4'hf;
      st_reg.port_lines <= 4'h0;
      st_reg.phase    <= ltbo_pkg::LTBO_IDLE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign rdata      = st_reg.rdata;
  assign port_lines = st_reg.port_lines;
  assign fail_flags = st_reg.fail;

endmodule
`default_nettype wire
